// [bwsr_regs.svh]
// register offsets, field positions, constant and fill values for the window block
`ifndef BWSR_REGS_SVH
`define BWSR_REGS_SVH
`define BWSR_OFF_CMD      8'h04
`define BWSR_OFF_IOWIN    8'h1c
`define BWSR_OFF_MEMWIN   8'h20
`define BWSR_OFF_IOUP     8'h30
`define BWSR_OFF_IRQMASK  8'h40
`define BWSR_IO_CAP       4'h1
`define BWSR_IO_LO_FILL   12'h000
`define BWSR_IO_HI_FILL   12'hfff
`define BWSR_MEM_LO_FILL  20'h0_0000
`define BWSR_MEM_HI_FILL  20'hf_ffff
`define BWSR_CMD_PERR_EN  6
`define BWSR_ST_66MHZ     21
`define BWSR_ST_FBB       23
`define BWSR_ST_MDPE      24
`define BWSR_ST_DEVSEL_LO 25
`define BWSR_ST_STA       27
`define BWSR_ST_RTA       28
`define BWSR_ST_RMA       29
`define BWSR_ST_RSE       30
`define BWSR_ST_DPE       31
`define BWSR_DEVSEL_MED   2'h1
`define BWSR_STICKY_MASK  32'hf900_0000
`define BWSR_RESP_OKAY    2'h0
`define BWSR_RESP_SLVERR  2'h2
`endif

// [bwsr_pkg.sv]
// types of the bridge window and secondary status block
`default_nettype none
package bwsr_pkg;
  typedef enum logic [1:0] {
    BWSR_WR_IDLE = 2'b01,
    BWSR_WR_RESP = 2'b10
  } bwsr_wr_t;

  // secondary bus events from same-clock bridge logic, one-cycle pulses
  typedef struct packed {
    logic parity_detected;
    logic master_abort_rcvd;
    logic target_abort_rcvd;
    logic target_abort_sent;
  } bwsr_evt_t;

  typedef struct packed {
    bwsr_wr_t    wr_st;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        perr_en;
    logic [3:0]  io_base_nib;
    logic [3:0]  io_lim_nib;
    logic [15:0] io_base_up;
    logic [15:0] io_lim_up;
    logic [11:0] mem_base;
    logic [11:0] mem_lim;
    logic [31:0] sts;
    logic [31:0] irq_mask;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic        io_hit;
    logic        mem_hit;
  } bwsr_state_t;
endpackage
`default_nettype wire

// [bwsr_top.sv]
// bridge i/o and memory windows, secondary status, axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bwsr_regs.svh"

module bwsr_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [7:0]         s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  input  wire logic               secondary_parity_error_in,
  input  wire logic               secondary_system_error_in,
  input  wire bwsr_pkg::bwsr_evt_t sec_evt,
  input  wire logic [31:0]        io_addr,
  input  wire logic [31:0]        mem_addr,
  output logic                    io_fwd,
  output logic                    mem_fwd,
  output logic                    irq
);
  import bwsr_pkg::*;

  bwsr_state_t q;
  bwsr_state_t n;
  logic [31:0] wr_word;
  logic [31:0] clr;
  logic [31:0] set;

  // ==========================================================
  // functions
  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    addr_ok = (w == `BWSR_OFF_CMD) || (w == `BWSR_OFF_IOWIN) ||
              (w == `BWSR_OFF_MEMWIN) || (w == `BWSR_OFF_IOUP) ||
              (w == `BWSR_OFF_IRQMASK);
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = (o & ~strb_mask(s)) | (d & strb_mask(s));
  endfunction

  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input bwsr_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case ({a[7:2], 2'b00})
      `BWSR_OFF_CMD: begin
        r[`BWSR_CMD_PERR_EN] = s.perr_en;
      end
      `BWSR_OFF_IOWIN: begin
        r = s.sts & `BWSR_STICKY_MASK;
        r[7:4]   = s.io_base_nib;
        r[3:0]   = `BWSR_IO_CAP;
        r[15:12] = s.io_lim_nib;
        r[11:8]  = `BWSR_IO_CAP;
        r[`BWSR_ST_66MHZ] = 1'b1;
        r[`BWSR_ST_FBB] = 1'b1;
        r[`BWSR_ST_DEVSEL_LO +: 2] = `BWSR_DEVSEL_MED;
      end
      `BWSR_OFF_MEMWIN: begin
        r = {s.mem_lim, 4'h0, s.mem_base, 4'h0};
      end
      `BWSR_OFF_IOUP: begin
        r = {s.io_lim_up, s.io_base_up};
      end
      `BWSR_OFF_IRQMASK: begin
        r = s.irq_mask;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    rd_word = r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    clr = 32'h0000_0000;
    set = 32'h0000_0000;
    wr_word = merge(rd_word(q.aw_addr, q), q.w_data, q.w_strb);

    // pin synchronisers
    n.sync1 = {secondary_system_error_in, secondary_parity_error_in};
    n.sync2 = q.sync1;

    // write channel
    case (q.wr_st)
      BWSR_WR_IDLE: begin
        if (s_axi_awvalid && !q.aw_got) begin
          n.aw_got = 1'b1;
          n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got) begin
          n.w_got = 1'b1;
          n.w_data = s_axi_wdata;
          n.w_strb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got) begin
          n.aw_got = 1'b0;
          n.w_got = 1'b0;
          n.wr_st = BWSR_WR_RESP;
          n.bresp = addr_ok(q.aw_addr) ? `BWSR_RESP_OKAY
                                       : `BWSR_RESP_SLVERR;
          case ({q.aw_addr[7:2], 2'b00})
            `BWSR_OFF_CMD: begin
              n.perr_en = wr_word[`BWSR_CMD_PERR_EN];
            end
            `BWSR_OFF_IOWIN: begin
              n.io_base_nib = wr_word[7:4];
              n.io_lim_nib = wr_word[15:12];
              clr = q.w_data & strb_mask(q.w_strb) &
                    `BWSR_STICKY_MASK;
            end
            `BWSR_OFF_MEMWIN: begin
              n.mem_base = wr_word[15:4];
              n.mem_lim = wr_word[31:20];
            end
            `BWSR_OFF_IOUP: begin
              n.io_base_up = wr_word[15:0];
              n.io_lim_up = wr_word[31:16];
            end
            `BWSR_OFF_IRQMASK: begin
              n.irq_mask = wr_word & `BWSR_STICKY_MASK;
            end
            default: begin
              n.bresp = `BWSR_RESP_SLVERR;
            end
          endcase
        end
      end
      BWSR_WR_RESP: begin
        if (s_axi_bready) begin
          n.wr_st = BWSR_WR_IDLE;
        end
      end
      default: begin
        n.wr_st = BWSR_WR_IDLE;
      end
    endcase

    // read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word(s_axi_araddr, q);
      n.rresp = addr_ok(s_axi_araddr) ? `BWSR_RESP_OKAY
                                      : `BWSR_RESP_SLVERR;
    end

    // sticky events, set wins over clear
    set[`BWSR_ST_MDPE] = q.sync2[0] && q.perr_en;
    set[`BWSR_ST_STA] = sec_evt.target_abort_sent;
    set[`BWSR_ST_RTA] = sec_evt.target_abort_rcvd;
    set[`BWSR_ST_RMA] = sec_evt.master_abort_rcvd;
    set[`BWSR_ST_RSE] = q.sync2[1];
    set[`BWSR_ST_DPE] = sec_evt.parity_detected;
    n.sts = ((q.sts & ~clr) | set) & `BWSR_STICKY_MASK;

    // forwarding windows
    n.io_hit = in_win(io_addr,
                      {q.io_base_up, q.io_base_nib,
                       `BWSR_IO_LO_FILL},
                      {q.io_lim_up, q.io_lim_nib,
                       `BWSR_IO_HI_FILL});
    n.mem_hit = in_win(mem_addr,
                       {q.mem_base, `BWSR_MEM_LO_FILL},
                       {q.mem_lim, `BWSR_MEM_HI_FILL});
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.wr_st <= BWSR_WR_IDLE;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = (q.wr_st == BWSR_WR_IDLE) && !q.aw_got;
  assign s_axi_wready  = (q.wr_st == BWSR_WR_IDLE) && !q.w_got;
  assign s_axi_bvalid  = (q.wr_st == BWSR_WR_RESP);
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign io_fwd        = q.io_hit;
  assign mem_fwd       = q.mem_hit;
  assign irq           = |(q.sts & q.irq_mask);

  // ==========================================================
  // assertions
  logic iowin_rd;
  logic memwin_rd;
  logic wr_fire;
  assign iowin_rd = s_axi_arvalid && s_axi_arready &&
                    ({s_axi_araddr[7:2], 2'b00} == `BWSR_OFF_IOWIN);
  assign memwin_rd = s_axi_arvalid && s_axi_arready &&
                     ({s_axi_araddr[7:2], 2'b00} == `BWSR_OFF_MEMWIN);
  assign wr_fire = (q.wr_st == BWSR_WR_IDLE) && q.aw_got && q.w_got;

  property p_io_cap;
    @(posedge aclk) disable iff (!aresetn)
      iowin_rd |=> s_axi_rvalid && s_axi_rdata[11:8] == 4'h1;
  endproperty
  a_io_cap: assert property (p_io_cap)
    else $error("i/o capability nibble not one");

  property p_sts_const;
    @(posedge aclk) disable iff (!aresetn)
      iowin_rd |=> s_axi_rdata[21] && s_axi_rdata[23] &&
                   s_axi_rdata[26:25] == 2'b01 &&
                   !s_axi_rdata[22] && s_axi_rdata[20:16] == 5'h00;
  endproperty
  a_sts_const: assert property (p_sts_const)
    else $error("secondary status constant bits wrong");

  property p_mem_low;
    @(posedge aclk) disable iff (!aresetn)
      memwin_rd |=> s_axi_rdata[3:0] == 4'h0 &&
                    s_axi_rdata[19:16] == 4'h0;
  endproperty
  a_mem_low: assert property (p_mem_low)
    else $error("memory window low nibble not zero");

  property p_io_lim_wr;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && q.w_strb[1] &&
      {q.aw_addr[7:2], 2'b00} == `BWSR_OFF_IOWIN
      |=> q.io_lim_nib == $past(q.w_data[15:12]);
  endproperty
  a_io_lim_wr: assert property (p_io_lim_wr)
    else $error("i/o limit nibble not written");

  property p_io_fwd;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> io_fwd == ($past(io_addr) >=
        {$past(q.io_base_up), $past(q.io_base_nib), 12'h000} &&
        $past(io_addr) <=
        {$past(q.io_lim_up), $past(q.io_lim_nib), 12'hfff});
  endproperty
  a_io_fwd: assert property (p_io_fwd)
    else $error("i/o forward decision wrong");

  property p_mem_fwd;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
      mem_fwd == ($past(mem_addr[31:20]) >= $past(q.mem_base) &&
                  $past(mem_addr[31:20]) <= $past(q.mem_lim));
  endproperty
  a_mem_fwd: assert property (p_mem_fwd)
    else $error("memory forward decision wrong");

  property p_perr;
    @(posedge aclk) disable iff (!aresetn)
      (secondary_parity_error_in && q.perr_en) [*3] |=> q.sts[24];
  endproperty
  a_perr: assert property (p_perr)
    else $error("parity pin did not set bit 24");

  property p_perr_off;
    @(posedge aclk) disable iff (!aresetn)
      !q.sts[24] && !(q.sync2[0] && q.perr_en) |=> !q.sts[24];
  endproperty
  a_perr_off: assert property (p_perr_off)
    else $error("bit 24 set without enabled parity pin");

  property p_serr;
    @(posedge aclk) disable iff (!aresetn)
      secondary_system_error_in [*3] |=> q.sts[30];
  endproperty
  a_serr: assert property (p_serr)
    else $error("system error pin did not set bit 30");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
      sec_evt.target_abort_sent || sec_evt.target_abort_rcvd ||
      sec_evt.master_abort_rcvd
      |=> (q.sts[27] || !$past(sec_evt.target_abort_sent)) &&
          (q.sts[28] || !$past(sec_evt.target_abort_rcvd)) &&
          (q.sts[29] || !$past(sec_evt.master_abort_rcvd));
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort event did not set its bit");

  property p_dpe;
    @(posedge aclk) disable iff (!aresetn)
      sec_evt.parity_detected |=> q.sts[31] [*2] or
      (q.sts[31] ##1 !q.sts[31]);
  endproperty
  a_dpe: assert property (p_dpe)
    else $error("detected parity did not set bit 31");

  property p_w1c;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && q.w_strb[3] && q.w_data[27] &&
      {q.aw_addr[7:2], 2'b00} == `BWSR_OFF_IOWIN &&
      !sec_evt.target_abort_sent |=> !q.sts[27];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear bit 27");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      q.sts[29] && q.irq_mask[29] |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked status without interrupt");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire || (s_axi_bvalid && !s_axi_bready)) |=>
        s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response dropped early");
endmodule
`default_nettype wire

// [bwsr_agent.sv]
// secondary bus agent model driving event pulses and error pins
`timescale 1ns/1ps
`default_nettype none
module bwsr_agent (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                go,
  input  wire logic [2:0]          sel,
  output var  logic                perr_pin,
  output var  logic                serr_pin,
  output var  bwsr_pkg::bwsr_evt_t evt
);
  import bwsr_pkg::*;
  logic [1:0] hold_q;
  // ==========================================================
  // events: one-cycle pulses; pins: high for three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt <= '0;
      hold_q <= 2'h0;
      perr_pin <= 1'b0;
      serr_pin <= 1'b0;
    end else begin
      evt <= (go && sel < 3'h4) ? bwsr_evt_t'(4'h1 << sel) : '0;
      if (go && sel >= 3'h4) begin
        hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
      if (go) begin
        perr_pin <= (sel == 3'h4);
        serr_pin <= (sel == 3'h5);
      end else if (hold_q == 2'h1) begin
        perr_pin <= 1'b0;
        serr_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [bwsr_top_test.sv]
// self-checking bench for the window and secondary status block
`timescale 1ns/1ps
`default_nettype none
`include "bwsr_regs.svh"
module bwsr_top_test;
  import bwsr_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        perr_pin, serr_pin, io_fwd, mem_fwd, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, io_addr, mem_addr, base, d;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic [2:0]  sel;
  bwsr_evt_t   evt;
  int          fail_count, check_count, cycles;
  int          bitpos [6] = '{27, 28, 29, 31, 24, 30};
  logic [31:0] io_t [4] = '{32'h0001_1fff, 32'h0001_2000,
                            32'h0001_3fff, 32'h0002_3000};
  logic [31:0] mem_t [4] = '{32'h0030_0000, 32'h002f_ffff,
                             32'h0060_0000, 32'h005f_ffff};
  logic [1:0]  fwd_e [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  // ==========================================================
  // clock, design and agent
  always #12.5 aclk = ~aclk;
  bwsr_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .secondary_parity_error_in(perr_pin),
    .secondary_system_error_in(serr_pin), .sec_evt(evt),
    .io_addr(io_addr), .mem_addr(mem_addr),
    .io_fwd(io_fwd), .mem_fwd(mem_fwd), .irq(irq)
  );
  bwsr_agent agent (
    .aclk(aclk), .aresetn(aresetn), .go(go), .sel(sel),
    .perr_pin(perr_pin), .serr_pin(serr_pin), .evt(evt)
  );
  // ==========================================================
  // tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [2:0] s);
    sel <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // ==========================================================
  // tests
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, go} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, sel} = '0;
    {wdata, io_addr, mem_addr} = '0;
    wstrb = 4'hf;
    {fail_count, check_count, cycles} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`BWSR_OFF_IOWIN, 32'h02a0_0101);
    chk({30'h0, resp}, 32'h0000_0000);
    rchk(`BWSR_OFF_MEMWIN, 32'h0000_0000);
    wr(`BWSR_OFF_IOWIN, 32'hffff_ffff);
    rchk(`BWSR_OFF_IOWIN, 32'h02a0_f1f1);
    wr(`BWSR_OFF_MEMWIN, 32'hffff_ffff);
    rchk(`BWSR_OFF_MEMWIN, 32'hfff0_fff0);
    wr(8'h10, 32'hffff_ffff);
    chk({30'h0, resp}, {30'h0, `BWSR_RESP_SLVERR});
    rd(8'h10, d);
    chk(d, 32'h0000_0000);
    chk({30'h0, resp}, {30'h0, `BWSR_RESP_SLVERR});
    wr(`BWSR_OFF_IOWIN, 32'h0000_3020);
    wr(`BWSR_OFF_IOUP, 32'h0001_0001);
    rchk(`BWSR_OFF_IOUP, 32'h0001_0001);
    wr(`BWSR_OFF_MEMWIN, 32'h0050_0030);
    for (int i = 0; i < 4; i++) begin
      io_addr <= io_t[i];
      mem_addr <= mem_t[i];
      @(posedge aclk);
      @(negedge aclk);
      chk({30'h0, io_fwd, mem_fwd}, {30'h0, fwd_e[i]});
      @(posedge aclk);
    end
    wstrb <= 4'h1;
    wr(`BWSR_OFF_MEMWIN, 32'hffff_ffff);
    wstrb <= 4'hf;
    rchk(`BWSR_OFF_MEMWIN, 32'h0050_00f0);
    base = 32'h02a0_3121;
    pulse(3'h4);
    rchk(`BWSR_OFF_IOWIN, base);
    wr(`BWSR_OFF_CMD, 32'h0000_0040);
    rchk(`BWSR_OFF_CMD, 32'h0000_0040);
    for (int i = 0; i < 6; i++) begin
      pulse(3'(i));
      rchk(`BWSR_OFF_IOWIN, base | (32'h1 << bitpos[i]));
      irq_chk(1'b0);
      wr(`BWSR_OFF_IRQMASK, 32'h1 << bitpos[i]);
      irq_chk(1'b1);
      wr(`BWSR_OFF_IOWIN, 32'h0000_3020);
      irq_chk(1'b1);
      wr(`BWSR_OFF_IOWIN, 32'h0000_3020 | (32'h1 << bitpos[i]));
      irq_chk(1'b0);
      rchk(`BWSR_OFF_IOWIN, base);
    end
    stop_test();
  end
endmodule
`default_nettype wire
